// ===== src/epam_port.sv
// eight-bit port with analog, comparator and slave-select sharing
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`default_nettype none

module epam_port
(
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	// register port
	input  wire logic [2:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	// comparator results, same clock
	input  wire logic       comparator_one_result_i,
	input  wire logic       comparator_two_result_i,
	// pins
	input  wire logic [7:0] pin_i,
	output logic      [7:0] pin_o,
	output logic      [7:0] pin_oe_n_o,
	// to converter, comparators and serial port
	output logic      [6:0] analog_chan_en_o,
	output logic      [3:0] comparator_in_en_o,
	output logic      [1:0] reference_select_o,
	output logic            comparator_reference_out_o,
	output logic            serial_slave_select_o
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [7:0] port_direction_bits_q;
	logic [7:0] port_direction_bits_d;
	logic [7:0] port_latch_bits_q;
	logic [7:0] port_latch_bits_d;
	logic [5:0] analog_config_reg_q;
	logic [5:0] analog_config_reg_d;
	logic [5:0] comparator_ctrl_reg_q;
	logic [5:0] comparator_ctrl_reg_d;
	logic [2:0] alt_func_q;
	logic [2:0] alt_func_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic [7:0] pin_meta_q;
	logic [7:0] pin_sync_q;
	logic [7:0] pin_out_q;
	logic [7:0] pin_out_d;
	logic [7:0] pin_oe_n_q;
	logic [7:0] pin_oe_n_d;
	logic [6:0] chan_en_q;
	logic [6:0] chan_en_d;
	logic [3:0] cmp_in_q;
	logic [3:0] cmp_in_d;
	logic       slave_q;
	logic       slave_d;
	logic [6:0] analog_sel;
	// analog decode
	logic [4:0] top_chan;
	// pin input stage next values
	logic [7:0] pin_meta_d;
	logic [7:0] pin_sync_d;
	logic       ref_out_q;
	logic       ref_out_d;
	// write enables
	logic       wr_direction;
	logic       wr_latch;
	logic       wr_analog;
	logic       wr_compare;
	logic       wr_alt_func;

	epam_mux_if mux_bus ();

	// ----------------------------------------
	// pin synchroniser
	// ----------------------------------------
	// pins are asynchronous; two stages before any reader
	always_comb
	begin
		pin_meta_d = pin_i;
		pin_sync_d = pin_meta_q;
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			pin_meta_q <= 8'h00;
			pin_sync_q <= 8'h00;
		end
		else
		begin
			pin_meta_q <= pin_meta_d;
			pin_sync_q <= pin_sync_d;
		end
	end

	// ----------------------------------------
	// analog selection decode
	// ----------------------------------------
	// a channel is analog while its index is at or below the
	// highest analog channel set by the port select field
	assign top_chan = 5'(epam_pkg::LAST_CONFIG)
		- {1'b0, analog_config_reg_q[epam_pkg::ANA_PORT_MSB:epam_pkg::ANA_PORT_LSB]};

	genvar g;

	generate
		for (g = 0; g < epam_pkg::ANALOG_PINS; g++)
		begin : g_chan
			// RULE_03 channels five to eleven
			assign analog_sel[g] = (5'(g + epam_pkg::FIRST_CHAN) <= top_chan);
		end
	endgenerate

	// ----------------------------------------
	// write decode
	// ----------------------------------------
	// one enable per register keeps each next-value path a plain mux
	always_comb
	begin
		wr_direction = 1'b0;
		wr_latch     = 1'b0;
		wr_analog    = 1'b0;
		wr_compare   = 1'b0;
		wr_alt_func  = 1'b0;
		if (wr_i)
		begin
			case (addr_i)
				epam_pkg::OFS_DIRECTION: wr_direction = 1'b1;
				// RULE_13 data write hits latch
				epam_pkg::OFS_PIN_DATA:  wr_latch = 1'b1;
				epam_pkg::OFS_LATCH:     wr_latch = 1'b1;
				epam_pkg::OFS_ANALOG:    wr_analog = 1'b1;
				epam_pkg::OFS_COMPARE:   wr_compare = 1'b1;
				epam_pkg::OFS_ALT_FUNC:  wr_alt_func = 1'b1;
				// unmapped offsets are ignored
				default:                 wr_latch = 1'b0;
			endcase
		end
	end

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	always_comb
	begin
		// RULE_09 one bit per pin
		port_direction_bits_d = wr_direction ? wdata_i : port_direction_bits_q;
		port_latch_bits_d     = wr_latch ? wdata_i : port_latch_bits_q;
		// RULE_10 top two bits dropped
		analog_config_reg_d   = wr_analog ? wdata_i[5:0] : analog_config_reg_q;
		// result bits are read-only
		comparator_ctrl_reg_d = wr_compare ? wdata_i[5:0] : comparator_ctrl_reg_q;
		alt_func_d            = wr_alt_func ? wdata_i[2:0] : alt_func_q;
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			port_direction_bits_q <= epam_pkg::RST_DIRECTION;
			port_latch_bits_q     <= epam_pkg::RST_LATCH;
			// RULE_12 analog after reset
			analog_config_reg_q   <= epam_pkg::RST_ANALOG;
			comparator_ctrl_reg_q <= epam_pkg::RST_COMPARE;
			alt_func_q            <= epam_pkg::RST_ALT_FUNC;
		end
		else
		begin
			port_direction_bits_q <= port_direction_bits_d;
			port_latch_bits_q     <= port_latch_bits_d;
			analog_config_reg_q   <= analog_config_reg_d;
			comparator_ctrl_reg_q <= comparator_ctrl_reg_d;
			alt_func_q            <= alt_func_d;
		end
	end

	// ----------------------------------------
	// pin multiplexer
	// ----------------------------------------
	assign mux_bus.direction   = port_direction_bits_q;
	assign mux_bus.latch       = port_latch_bits_q;
	assign mux_bus.analog_sel  = analog_sel;
	assign mux_bus.cmp_out_en  = alt_func_q[epam_pkg::ALT_CMP_OUT];
	assign mux_bus.ref_out_en  = alt_func_q[epam_pkg::ALT_REF_OUT];
	assign mux_bus.cmp_one_res = comparator_one_result_i;
	assign mux_bus.cmp_two_res = comparator_two_result_i;
	assign mux_bus.pin_level   = pin_sync_q;

	epam_pin_mux u_mux
	(
		.m (mux_bus.mux)
	);

	// ----------------------------------------
	// register reads
	// ----------------------------------------
	// data stands only in the cycle after the strobe
	always_comb
	begin
		rdata_d = 8'h00;
		if (rd_i)
		begin
			case (addr_i)
				epam_pkg::OFS_DIRECTION: rdata_d = port_direction_bits_q;
				// RULE_02 gated pin levels
				epam_pkg::OFS_PIN_DATA:  rdata_d = mux_bus.digital_in;
				// RULE_11 latch, not pins
				epam_pkg::OFS_LATCH:     rdata_d = port_latch_bits_q;
				// RULE_10 unimplemented read zero
				epam_pkg::OFS_ANALOG:    rdata_d = {2'h0, analog_config_reg_q};
				// results are read live, never stored
				epam_pkg::OFS_COMPARE:
				begin
					rdata_d[5:0]                   = comparator_ctrl_reg_q;
					rdata_d[epam_pkg::CMP_ONE_RES] = comparator_one_result_i;
					rdata_d[epam_pkg::CMP_TWO_RES] = comparator_two_result_i;
				end
				epam_pkg::OFS_ALT_FUNC:  rdata_d = {5'h00, alt_func_q};
				default:                 rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			rdata_q <= 8'h00;
		end
		else
		begin
			rdata_q <= rdata_d;
		end
	end

	// ----------------------------------------
	// pin drive
	// ----------------------------------------
	// outputs are registered, so a register write reaches the pin
	// one edge after the write; traded for clean flop-driven pins
	always_comb
	begin
		// RULE_01 driven from latch
		pin_out_d  = mux_bus.drive_val;
		// RULE_06 enable is low while driving
		pin_oe_n_d = ~mux_bus.drive_en;
		// RULE_06 reference in step with enable
		// so the reference never meets an active driver
		ref_out_d  = alt_func_q[epam_pkg::ALT_REF_OUT];
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			pin_out_q  <= 8'h00;
			pin_oe_n_q <= 8'hFF;
			ref_out_q  <= 1'b0;
		end
		else
		begin
			pin_out_q  <= pin_out_d;
			pin_oe_n_q <= pin_oe_n_d;
			ref_out_q  <= ref_out_d;
		end
	end

	// ----------------------------------------
	// converter and comparator routing
	// ----------------------------------------
	always_comb
	begin
		// RULE_03 converter channel enables
		chan_en_d = analog_sel;
		// RULE_04 comparator input routing
		cmp_in_d  = analog_sel[6:3];
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			chan_en_q <= 7'h7F;
			cmp_in_q  <= 4'hF;
		end
		else
		begin
			chan_en_q <= chan_en_d;
			cmp_in_q  <= cmp_in_d;
		end
	end

	// ----------------------------------------
	// slave select
	// ----------------------------------------
	// an unused select idles inactive so the serial port stays deselected
	always_comb
	begin
		// RULE_07 slave select path
		if (alt_func_q[epam_pkg::ALT_SLAVE] && port_direction_bits_q[epam_pkg::PIN_SLAVE])
		begin
			slave_d = pin_sync_q[epam_pkg::PIN_SLAVE];
		end
		else
		begin
			slave_d = epam_pkg::SLAVE_IDLE;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			slave_q <= epam_pkg::SLAVE_IDLE;
		end
		else
		begin
			slave_q <= slave_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign rdata_o                    = rdata_q;
	assign pin_o                      = pin_out_q;
	assign pin_oe_n_o                 = pin_oe_n_q;
	assign analog_chan_en_o           = chan_en_q;
	// order: comparator two plus, two minus, one plus, one minus
	assign comparator_in_en_o         = cmp_in_q;
	assign reference_select_o         =
		analog_config_reg_q[epam_pkg::ANA_REF_MSB:epam_pkg::ANA_REF_LSB];
	assign comparator_reference_out_o = ref_out_q;
	assign serial_slave_select_o      = slave_q;

endmodule

`default_nettype wire

// ===== inc/epam_pkg.sv
// constants shared by the eight-bit analog-muxed port
// Behaviour
// RULE_01: direction 0 drives the pin from the latch; analog selection never alters it.
// RULE_02: direction 1 reads the sampled pin, but analog selection disables that input.
// RULE_03: pins zero to six are converter channels 5 to 11, analog after reset.
// RULE_04: pins three to six also feed comparator two plus/minus, one plus/minus.
// RULE_05: comparator output enabled and direction 0: pin one/two carry comparator results.
// RULE_06: reference output enabled disables pin five driver and input, whatever direction.
// RULE_07: pin seven is the serial slave select when enabled and set as input.
// RULE_08: software writes 0x0F to analog config before using the pins digitally.
// RULE_09: each direction bit n controls pin n alone; 0xCF makes pins five, four outputs.
// RULE_10: analog config bits 7 and 6 read zero; 5:4 reference, 3:0 port select.
// RULE_11: reading the latch register returns the latch, not the pin level.
// RULE_12: after reset pins six to zero are analog and read as zero.
// RULE_13: writing the pin data register updates the output latch.
`default_nettype none

package epam_pkg;

	// ----------------------------------------
	// sizes
	// ----------------------------------------
	localparam int unsigned PIN_COUNT    = 8;
	localparam int unsigned ANALOG_PINS  = 7;
	localparam int unsigned ADDR_WIDTH   = 3;
	localparam int unsigned DATA_WIDTH   = 8;
	localparam int unsigned FIRST_CHAN   = 5;
	localparam int unsigned LAST_CONFIG  = 15;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [2:0] OFS_DIRECTION = 3'h0;
	localparam logic [2:0] OFS_PIN_DATA  = 3'h1;
	localparam logic [2:0] OFS_LATCH     = 3'h2;
	localparam logic [2:0] OFS_ANALOG    = 3'h3;
	localparam logic [2:0] OFS_COMPARE   = 3'h4;
	localparam logic [2:0] OFS_ALT_FUNC  = 3'h5;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] RST_DIRECTION = 8'hFF;
	localparam logic [7:0] RST_LATCH     = 8'h00;
	localparam logic [5:0] RST_ANALOG    = 6'h00;
	localparam logic [5:0] RST_COMPARE   = 6'h07;
	localparam logic [2:0] RST_ALT_FUNC  = 3'h0;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int unsigned ANA_PORT_LSB = 0;
	localparam int unsigned ANA_PORT_MSB = 3;
	localparam int unsigned ANA_REF_LSB  = 4;
	localparam int unsigned ANA_REF_MSB  = 5;
	localparam int unsigned CMP_TWO_RES  = 7;
	localparam int unsigned CMP_ONE_RES  = 6;
	localparam int unsigned ALT_CMP_OUT  = 0;
	localparam int unsigned ALT_REF_OUT  = 1;
	localparam int unsigned ALT_SLAVE    = 2;

	// ----------------------------------------
	// special pins
	// ----------------------------------------
	localparam int unsigned PIN_CMP_TWO  = 1;
	localparam int unsigned PIN_CMP_ONE  = 2;
	localparam int unsigned PIN_REF      = 5;
	localparam int unsigned PIN_SLAVE    = 7;
	localparam int unsigned PIN_C2_POS   = 3;

	// slave select idles high when the function is unused
	localparam logic        SLAVE_IDLE   = 1'b1;

endpackage

`default_nettype wire

// ===== inc/epam_mux_if.sv
// signals between the register core and the pin multiplexer
`default_nettype none

interface epam_mux_if;
	logic [7:0] direction;
	logic [7:0] latch;
	logic [6:0] analog_sel;
	logic       cmp_out_en;
	logic       ref_out_en;
	logic       cmp_one_res;
	logic       cmp_two_res;
	logic [7:0] pin_level;
	logic [7:0] drive_val;
	logic [7:0] drive_en;
	logic [7:0] digital_in;

	modport core
	(
		output direction,
		output latch,
		output analog_sel,
		output cmp_out_en,
		output ref_out_en,
		output cmp_one_res,
		output cmp_two_res,
		output pin_level,
		input  drive_val,
		input  drive_en,
		input  digital_in
	);

	modport mux
	(
		input  direction,
		input  latch,
		input  analog_sel,
		input  cmp_out_en,
		input  ref_out_en,
		input  cmp_one_res,
		input  cmp_two_res,
		input  pin_level,
		output drive_val,
		output drive_en,
		output digital_in
	);
endinterface

`default_nettype wire

// ===== src/epam_pin_mux.sv
// per-pin output select, driver enable and digital input gating
`default_nettype none

module epam_pin_mux
(
	// core side
	epam_mux_if.mux m
);

	genvar g;

	generate
		for (g = 0; g < 8; g++)
		begin : g_pin
			logic analog;
			logic ref_pin;
			logic alt_val;
			logic alt_use;

			if (g < 7)
			begin : g_ana
				assign analog = m.analog_sel[g];
			end
			else
			begin : g_dig
				assign analog = 1'b0;
			end

			assign ref_pin = (g == epam_pkg::PIN_REF) && m.ref_out_en;

			// RULE_05 comparator result override
			assign alt_use = m.cmp_out_en && !m.direction[g]
				&& ((g == epam_pkg::PIN_CMP_TWO) || (g == epam_pkg::PIN_CMP_ONE));
			assign alt_val = (g == epam_pkg::PIN_CMP_TWO) ? m.cmp_two_res : m.cmp_one_res;

			// RULE_01 latch drives, analog ignored
			assign m.drive_val[g] = alt_use ? alt_val : m.latch[g];

			// RULE_06 reference kills driver
			assign m.drive_en[g] = !m.direction[g] && !ref_pin;

			// RULE_02 analog or reference blocks input
			assign m.digital_in[g] = (analog || ref_pin) ? 1'b0 : m.pin_level[g];
		end
	endgenerate

endmodule

`default_nettype wire

// ===== test/epam_port_assertions.sv
// concurrent checks on the ports of the analog-muxed port
`default_nettype none

module epam_port_assertions
(
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	// register port
	input  wire logic [2:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	input  wire logic [7:0] rdata_o,
	// pins and peripheral enables
	input  wire logic [7:0] pin_o,
	input  wire logic [7:0] pin_oe_n_o,
	input  wire logic [6:0] analog_chan_en_o,
	input  wire logic [3:0] comparator_in_en_o,
	input  wire logic [1:0] reference_select_o,
	input  wire logic       comparator_reference_out_o,
	input  wire logic       serial_slave_select_o
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	// latch drives pins; pins one and two masked, comparators may own them
	AST_LATCH_DRIVE: assert property ((wr_i && (addr_i == 3'h2 || addr_i == 3'h1))
		|-> ##2 (pin_o & 8'hF9) == ($past(wdata_i, 2) & 8'hF9)) else $error("pin drive off");
	AST_DIR: assert property ((wr_i && addr_i == 3'h0)
		|-> ##2 (pin_oe_n_o & 8'hDF) == ($past(wdata_i, 2) & 8'hDF)) else $error("direction off");
	AST_REF_SEL: assert property ((wr_i && addr_i == 3'h3)
		|-> ##2 {2'h0, reference_select_o, 4'h0} == ($past(wdata_i, 2) & 8'h30))
		else $error("reference select off");
	AST_ALL_DIGITAL: assert property ((wr_i && addr_i == 3'h3 && wdata_i[3:0] == 4'hF)
		|-> ##2 analog_chan_en_o == 7'h00) else $error("analog left on");
	AST_ALL_ANALOG: assert property ((wr_i && addr_i == 3'h3 && wdata_i[3:0] == 4'h0)
		|-> ##2 analog_chan_en_o == 7'h7F) else $error("analog not on");
	AST_CMP_IN: assert property (comparator_in_en_o == analog_chan_en_o[6:3])
		else $error("comparator input map off");
	AST_ANA_HI: assert property ((rd_i && addr_i == 3'h3) |=> rdata_o[7:6] == 2'h0)
		else $error("analog config top bits set");
	AST_GATED: assert property ((rd_i && addr_i == 3'h1)
		|=> (rdata_o[6:0] & analog_chan_en_o) == 7'h00) else $error("analog pin read");
	AST_REF_OFF: assert property (comparator_reference_out_o |-> pin_oe_n_o[5])
		else $error("pin five driven");
	AST_SS_IDLE: assert property ((!pin_oe_n_o[7] && !$past(pin_oe_n_o[7]))
		|-> serial_slave_select_o) else $error("slave select active");
	AST_RESET: assert property ($past(reset_i)
		|-> pin_oe_n_o == 8'hFF && analog_chan_en_o == 7'h7F) else $error("reset state off");
endmodule

bind epam_port epam_port_assertions chk_u
(
	.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
	.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o),
	.analog_chan_en_o(analog_chan_en_o), .comparator_in_en_o(comparator_in_en_o),
	.reference_select_o(reference_select_o),
	.comparator_reference_out_o(comparator_reference_out_o),
	.serial_slave_select_o(serial_slave_select_o)
);

`default_nettype wire

// ===== test/epam_board.sv
// board-side model of the port pins
`default_nettype none

module epam_board
(
	// device side
	input  wire logic       clk_i,
	input  wire logic [7:0] dev_val_i,
	input  wire logic [7:0] dev_oe_n_i,
	// board stimulus
	input  wire logic [7:0] ext_val_i,
	input  wire logic [7:0] ext_en_i,
	output logic      [7:0] pin_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] float_q = 8'h00;

	// floating pins wander, so a stale level is never read back
	always @(posedge clk_i)
		float_q <= ~float_q;
	// device drive wins, then the board, else the wandering level
	assign pin_o = (~dev_oe_n_i & dev_val_i) | (dev_oe_n_i & ext_en_i & ext_val_i)
		| (dev_oe_n_i & ~ext_en_i & float_q);
endmodule

`default_nettype wire

// ===== test/tb.sv
// self-checking bench for the analog-muxed port
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk_i   = 1'b0;
	logic       reset_i = 1'b1;
	logic [2:0] addr_i  = 3'h0;
	logic [7:0] wdata_i = 8'h00;
	logic       wr_i    = 1'b0;
	logic       rd_i    = 1'b0;
	logic       c1      = 1'b0;
	logic       c2      = 1'b0;
	logic [7:0] ext_val = 8'h80;
	logic [7:0] ext_en  = 8'h80;
	logic       rd_d    = 1'b0;
	wire  logic [7:0] pin_i, pin_o, oe_n, rdata_o;
	wire  logic [6:0] ana;
	wire  logic [3:0] cin;
	wire  logic [1:0] rsel;
	wire  logic       rout, ss;
	logic [7:0] exp_q[$];
	logic [7:0] rst_t[8] = '{8'hFF, 8'h80, 8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'h00};
	logic [7:0] r, e;
	logic [6:0] m;
	int         n_fail = 0;
	int         n_compared = 0;

	always #20 clk_i = ~clk_i;

	epam_port dut_u
	(
		.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .comparator_one_result_i(c1),
		.comparator_two_result_i(c2), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n_o(oe_n),
		.analog_chan_en_o(ana), .comparator_in_en_o(cin), .reference_select_o(rsel),
		.comparator_reference_out_o(rout), .serial_slave_select_o(ss)
	);

	epam_board board_u
	(
		.clk_i(clk_i), .dev_val_i(pin_o), .dev_oe_n_i(oe_n), .ext_val_i(ext_val),
		.ext_en_i(ext_en), .pin_o(pin_i)
	);

	task automatic end_sim;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
		n_compared++;
		if (got !== ex)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, ex, got);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, input logic [7:0] ex);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		exp_q.push_back(ex);
		@(posedge clk_i);
		rd_i <= 1'b0;
	endtask

	task automatic wt;
		repeat (4) @(posedge clk_i);
	endtask

	// read data stands only in the cycle after the strobe
	always @(posedge clk_i)
	begin
		if (rd_d)
		begin
			chk("rdata", exp_q[0], rdata_o);
			void'(exp_q.pop_front());
		end
		rd_d <= rd_i;
	end

	initial
	begin
		repeat (20000) @(posedge clk_i);
		n_fail++;
		end_sim();
	end

	initial
	begin
		void'($urandom(17627));
		repeat (20) @(posedge clk_i);
		reset_i <= 1'b0;
		wt();
		chk("oe_n", 8'hFF, oe_n);
		chk("ss", 8'h01, {7'h00, ss});
		for (int i = 0; i < 8; i++)
			rd(i[2:0], rst_t[i]);
		for (int i = 0; i < 16; i++)
		begin
			wr(3'h3, 8'hF0 | i[7:0]);
			wt();
			m = (i > 10) ? 7'h00 : 7'h7F >> ((i > 4) ? i - 4 : 0);
			chk("ana", {1'b0, m}, {1'b0, ana});
			chk("cin", {4'h0, m[6:3]}, {4'h0, cin});
			rd(3'h3, 8'h30 | i[7:0]);
		end
		chk("rsel", 8'h03, {6'h00, rsel});
		ext_en <= 8'h00;
		wr(3'h3, 8'h00);
		r = 8'($urandom);
		wr(3'h2, r);
		wr(3'h0, 8'h00);
		wt();
		chk("pin", r, pin_o);
		chk("oe_n", 8'h00, oe_n);
		rd(3'h1, {r[7], 7'h00});
		// software must switch analog off before digital use
		wr(3'h3, 8'h0F);
		wr(3'h0, 8'hCF);
		e = 8'($urandom);
		ext_en <= 8'hCF;
		ext_val <= e;
		wt();
		chk("oe_n", 8'hCF, oe_n);
		rd(3'h1, (e & 8'hCF) | (r & 8'h30));
		wr(3'h1, ~r);
		rd(3'h2, ~r);
		wt();
		chk("pin", ~r, pin_o);
		ext_en <= 8'h00;
		wr(3'h0, 8'h00);
		wr(3'h5, 8'h01);
		c1 <= 1'b1;
		wt();
		chk("pin", (~r & 8'hF9) | 8'h04, pin_o);
		rd(3'h4, 8'h47);
		c1 <= 1'b0;
		c2 <= 1'b1;
		wt();
		chk("pin", (~r & 8'hF9) | 8'h02, pin_o);
		ext_en <= 8'h20;
		ext_val <= 8'h20;
		wr(3'h5, 8'h02);
		wt();
		chk("oe_n", 8'h20, oe_n);
		chk("rout", 8'h01, {7'h00, rout});
		rd(3'h1, ~r & 8'hDF);
		wr(3'h5, 8'h04);
		wr(3'h0, 8'h80);
		ext_en <= 8'h80;
		ext_val <= 8'h00;
		wt();
		chk("ss", 8'h00, {7'h00, ss});
		ext_val <= 8'h80;
		wt();
		chk("ss", 8'h01, {7'h00, ss});
		wr(3'h7, 8'h55);
		rd(3'h0, 8'h80);
		wr(3'h4, 8'hC0);
		rd(3'h4, 8'h80);
		repeat (4) @(posedge clk_i);
		end_sim();
	end
endmodule

`default_nettype wire
